// File: hdl/usb_ep_pkg.sv
package usb_ep_pkg;

  // ----------------------------------------------------------------
  // indexed register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_IN_IE  = 8'h07;
  localparam logic [7:0] IDX_OUT_IE = 8'h09;
  localparam logic [7:0] IDX_CM_IE  = 8'h0B;
  localparam logic [7:0] IDX_EP_SEL = 8'h0E;
  localparam logic [7:0] IDX_CSRL   = 8'h11;
  localparam logic [7:0] IDX_CSRH   = 8'h12;
  localparam logic [7:0] IDX_EP_ZERO_BYTE_COUNT  = 8'h16;
  localparam logic [7:0] IDX_EN     = 8'h1E;
  localparam logic [7:0] IDX_FIFO   = 8'h20;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_IN_IE  = 4'hF;
  localparam logic [2:0] RST_OUT_IE = 3'h7;
  localparam logic [3:0] RST_CM_IE  = 4'h6;
  localparam logic [3:0] RST_EN     = 4'hF;

  // ----------------------------------------------------------------
  // endpoint 0 control bits
  // ----------------------------------------------------------------
  localparam int E0_SERVICED_SETUP_END = 7;
  localparam int E0_SERVICED_OUT_READY = 6;
  localparam int E0_SEND_STALL  = 5;
  localparam int E0_SETUP_END  = 4;
  localparam int E0_DEND   = 3;
  localparam int E0_SENT_STALL  = 2;
  localparam int E0_INRDY  = 1;
  localparam int E0_OUT_PACKET_READY  = 0;

  // ----------------------------------------------------------------
  // in endpoint control bits
  // ----------------------------------------------------------------
  localparam int IL_CLEAR_DATA_TOGGLE  = 6;
  localparam int IL_SENT_STALL  = 5;
  localparam int IL_SEND_STALL  = 4;
  localparam int IL_FLUSH  = 3;
  localparam int IL_UNDR   = 2;
  localparam int IL_FNE    = 1;
  localparam int IL_INRDY  = 0;
  localparam int IH_IN_DOUBLE_BUFFER_EN  = 7;
  localparam int IH_ISO    = 6;
  localparam int IH_DIRECTION_SELECT = 5;
  localparam int IH_FORCE_TOGGLE   = 3;
  localparam int IH_SPLIT  = 2;
  localparam int IH_ISOCHRONOUS_UPDATE  = 0;
  localparam logic [7:0] IH_MASK = 8'hED;

  // ----------------------------------------------------------------
  // fifo shape and token replies
  // ----------------------------------------------------------------
  localparam int FIFO_W     = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [4:0] {
    RPL_NONE  = 5'h01,
    RPL_NAK   = 5'h02,
    RPL_DATA  = 5'h04,
    RPL_STALL = 5'h08,
    RPL_ZLP   = 5'h10
  } reply_t;

endpackage

// File: hdl/stream_if.sv
`timescale 1ns/10ps
interface stream_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  logic       flush;
  modport src (output data, output valid, output flush, input ready);
  modport snk (input data, input valid, input flush, output ready);
endinterface

// File: hdl/byte_fifo.sv
`timescale 1ns/10ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // streams
  stream_if.snk     in_s,
  stream_if.src     out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] LIMIT = CW'(DEPTH - 2);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    space;
    logic                    ov;
    logic [W-1:0]            od;
  } fifo_t;

  fifo_t r;
  fifo_t n;

  // ----------------------------------------------------------------
  // storage and output stage
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    // output stage refills whenever it is empty or being taken
    if (r.ov && out_s.ready) begin
      n.ov = 1'b0;
    end
    if (!n.ov && r.cnt != '0) begin
      n.ov = 1'b1;
      n.od = r.mem[r.rp];
      n.rp = AW'(r.rp + 1'b1);
      n.cnt = CW'(r.cnt - 1'b1);
    end
    if (in_s.valid && r.cnt != CW'(DEPTH)) begin
      n.mem[r.wp] = in_s.data;
      n.wp = AW'(r.wp + 1'b1);
      n.cnt = CW'(n.cnt + 1'b1);
    end
    if (in_s.flush) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
      n.ov = 1'b0;
    end
    // one slot of margin: the writer pushes a cycle after it sees ready
    n.space = (n.cnt <= LIMIT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign in_s.ready  = r.space;
  assign out_s.valid = r.ov;
  assign out_s.data  = r.od;
  assign out_s.flush = in_s.flush;

endmodule

// File: hdl/usb_ep_ctrl.sv
`timescale 1ns/10ps
module usb_ep_ctrl (
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       ARST_N,
  // firmware index/data port
  input  wire logic       REG_SEL,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  output logic            FIFO_READY,
  // serial engine events
  input  wire logic       LNK_IN_TOKEN,
  input  wire logic       LNK_IN_SENT,
  input  wire logic [1:0] LNK_TOKEN_EP,
  input  wire logic       LNK_EP0_RX,
  input  wire logic [6:0] LNK_EP0_COUNT,
  input  wire logic       LNK_EP0_OVERWRITE,
  input  wire logic       LNK_SETUP_END,
  input  wire logic       LNK_STATUS_DONE,
  input  wire logic       LNK_SOF,
  input  wire logic       LNK_BUS_RESET,
  input  wire logic       LNK_RESUME,
  input  wire logic       LNK_SUSPEND,
  input  wire logic [2:0] LNK_OUT_RX,
  // transmit data
  output logic      [7:0] TX_DATA,
  output logic            TX_VALID,
  input  wire logic       TX_READY,
  // replies and endpoint setup
  output logic      [4:0] IN_REPLY,
  output logic      [1:0] IN_REPLY_EP,
  output logic      [3:0] HS_EN,
  output logic      [2:0] EP_DIR_IN,
  output logic      [2:0] EP_SPLIT,
  output logic      [2:0] FORCE_TOGGLE,
  output logic      [2:0] DT_CLEAR,
  // gated interrupt events
  output logic      [3:0] IRQ_IN,
  output logic      [2:0] IRQ_OUT,
  output logic      [3:0] IRQ_CM
);

  typedef struct packed {
    logic [7:0]      idx;
    logic [1:0]      ep_sel;
    logic [3:0]      in_ie;
    logic [2:0]      out_ie;
    logic [3:0]      cm_ie;
    logic [3:0]      ep_en;
    logic            e0_send_stall;
    logic            e0_setup_end;
    logic            e0_data_end;
    logic            e0_sent_stall;
    logic            e0_in_ready;
    logic            e0_out_ready;
    logic [6:0]      e0_count;
    logic [2:0]      sent_stall;
    logic [2:0]      send_stall;
    logic [2:0]      underrun;
    logic [2:0]      in_ready;
    logic [2:0]      iso_hold;
    logic [2:0][1:0] pkts;
    logic [2:0][7:0] hi;
    logic [7:0]      rdata;
    usb_ep_pkg::reply_t reply;
    logic [1:0]      reply_ep;
    logic [3:0]      hs_en;
    logic [2:0]      dir_in;
    logic [2:0]      split;
    logic [2:0]      force_tgl;
    logic [2:0]      dt_clear;
    logic [3:0]      irq_in;
    logic [2:0]      irq_out;
    logic [3:0]      irq_cm;
    logic            fw_valid;
    logic [7:0]      fw_data;
    logic            fw_flush;
  } state_t;

  state_t     r;
  state_t     n;
  logic [1:0] s;
  logic [1:0] t;
  logic       dwr;
  logic       e0_sel;
  logic [7:0] rd_val;

  stream_if fw_s ();
  stream_if tx_s ();

  // maps endpoint 1..3 onto array slot 0..2
  function automatic logic [1:0] ep_slot(input logic [1:0] ep);
    ep_slot = 2'(ep - 2'h1);
  endfunction

  assign s      = ep_slot(r.ep_sel);
  assign t      = ep_slot(LNK_TOKEN_EP);
  assign dwr    = REG_WR && REG_SEL;
  assign e0_sel = (r.ep_sel == 2'h0);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    case (r.idx)
      usb_ep_pkg::IDX_IN_IE:  rd_val = {4'h0, r.in_ie};
      usb_ep_pkg::IDX_OUT_IE: rd_val = {4'h0, r.out_ie, 1'b0};
      usb_ep_pkg::IDX_CM_IE:  rd_val = {4'h0, r.cm_ie};
      usb_ep_pkg::IDX_EP_SEL: rd_val = {6'h00, r.ep_sel};
      usb_ep_pkg::IDX_EN:     rd_val = {4'h0, r.ep_en};
      usb_ep_pkg::IDX_EP_ZERO_BYTE_COUNT: begin
        if (e0_sel) begin
          rd_val = {1'b0, r.e0_count};
        end
      end
      usb_ep_pkg::IDX_CSRL: begin
        if (e0_sel) begin
          rd_val = {3'h0, r.e0_setup_end, r.e0_data_end, r.e0_sent_stall,
                    r.e0_in_ready, r.e0_out_ready};
        end else begin
          rd_val = {2'h0, r.sent_stall[s], r.send_stall[s], 1'b0,
                    r.underrun[s], r.pkts[s] != 2'h0,
                    r.in_ready[s] && !r.iso_hold[s]};
        end
      end
      usb_ep_pkg::IDX_CSRH: begin
        if (!e0_sel) begin
          rd_val = r.hi[s];
        end
      end
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.reply    = usb_ep_pkg::RPL_NONE;
    n.dt_clear = 3'h0;
    n.irq_in   = 4'h0;
    n.fw_valid = 1'b0;
    n.fw_flush = 1'b0;
    n.irq_cm   = r.cm_ie & {LNK_SOF, LNK_BUS_RESET, LNK_RESUME,
                            LNK_SUSPEND};
    n.irq_out  = r.out_ie & LNK_OUT_RX;

    if (REG_RD) begin
      n.rdata = REG_SEL ? rd_val : r.idx;
    end
    if (REG_WR && !REG_SEL) begin
      n.idx = REG_WDATA;
    end

    // firmware writes come first so hardware sets win a same-cycle clear
    if (dwr) begin
      case (r.idx)
        usb_ep_pkg::IDX_IN_IE:  n.in_ie  = REG_WDATA[3:0];
        usb_ep_pkg::IDX_OUT_IE: n.out_ie = REG_WDATA[3:1];
        usb_ep_pkg::IDX_CM_IE:  n.cm_ie  = REG_WDATA[3:0];
        usb_ep_pkg::IDX_EP_SEL: n.ep_sel = REG_WDATA[1:0];
        usb_ep_pkg::IDX_EN:     n.ep_en  = REG_WDATA[3:0];
        usb_ep_pkg::IDX_FIFO: begin
          // dropped when full; firmware polls the ready flag first
          if (fw_s.ready) begin
            n.fw_valid = 1'b1;
            n.fw_data  = REG_WDATA;
          end
        end
        usb_ep_pkg::IDX_CSRL: begin
          if (e0_sel) begin
            if (REG_WDATA[usb_ep_pkg::E0_SERVICED_SETUP_END]) begin
              n.e0_setup_end = 1'b0;
            end
            if (REG_WDATA[usb_ep_pkg::E0_SERVICED_OUT_READY]) begin
              n.e0_out_ready = 1'b0;
            end
            n.e0_send_stall = REG_WDATA[usb_ep_pkg::E0_SEND_STALL];
            if (REG_WDATA[usb_ep_pkg::E0_DEND]) begin
              n.e0_data_end = 1'b1;
            end
            if (!REG_WDATA[usb_ep_pkg::E0_SENT_STALL]) begin
              n.e0_sent_stall = 1'b0;
            end
            if (REG_WDATA[usb_ep_pkg::E0_INRDY]) begin
              n.e0_in_ready = 1'b1;
            end
          end else begin
            n.dt_clear[s]   = REG_WDATA[usb_ep_pkg::IL_CLEAR_DATA_TOGGLE];
            n.send_stall[s] = REG_WDATA[usb_ep_pkg::IL_SEND_STALL];
            if (!REG_WDATA[usb_ep_pkg::IL_SENT_STALL]) begin
              n.sent_stall[s] = 1'b0;
            end
            if (!REG_WDATA[usb_ep_pkg::IL_UNDR]) begin
              n.underrun[s] = 1'b0;
            end
            if (REG_WDATA[usb_ep_pkg::IL_FLUSH]) begin
              // one shared fifo: a flush drops every endpoint's bytes
              n.pkts[s]     = 2'h0;
              n.in_ready[s] = 1'b0;
              n.fw_flush    = 1'b1;
            end else if (REG_WDATA[usb_ep_pkg::IL_INRDY] &&
                         r.pkts[s] < (r.hi[s][usb_ep_pkg::IH_IN_DOUBLE_BUFFER_EN] ?
                                      2'h2 : 2'h1)) begin
              n.pkts[s] = 2'(r.pkts[s] + 2'h1);
              // a second slot is still open: release in ready at once
              n.in_ready[s] = !(r.hi[s][usb_ep_pkg::IH_IN_DOUBLE_BUFFER_EN] &&
                                r.pkts[s] == 2'h0);
              if (r.hi[s][usb_ep_pkg::IH_ISO] &&
                  r.hi[s][usb_ep_pkg::IH_ISOCHRONOUS_UPDATE]) begin
                n.iso_hold[s] = 1'b1;
              end
            end
          end
        end
        usb_ep_pkg::IDX_CSRH: begin
          if (!e0_sel) begin
            n.hi[s] = REG_WDATA & usb_ep_pkg::IH_MASK;
          end
        end
        default: ;
      endcase
    end

    // endpoint 0 events
    if (LNK_EP0_RX) begin
      n.e0_out_ready = 1'b1;
      n.e0_count     = LNK_EP0_COUNT;
      n.irq_in[0]    = r.in_ie[0];
    end
    if (r.e0_in_ready && (LNK_EP0_OVERWRITE ||
        (LNK_IN_SENT && LNK_TOKEN_EP == 2'h0))) begin
      n.e0_in_ready = 1'b0;
      n.irq_in[0]   = r.in_ie[0];
    end
    if (LNK_SETUP_END && !r.e0_data_end) begin
      n.e0_setup_end = 1'b1;
    end
    if (LNK_STATUS_DONE && !dwr) begin
      n.e0_data_end = 1'b0;
    end
    if (LNK_SOF) begin
      n.iso_hold = 3'h0;
    end

    // token replies
    if (LNK_IN_TOKEN) begin
      n.reply_ep = LNK_TOKEN_EP;
      if (LNK_TOKEN_EP == 2'h0) begin
        if (r.e0_send_stall) begin
          n.reply         = usb_ep_pkg::RPL_STALL;
          n.e0_sent_stall = 1'b1;
        end else if (r.e0_in_ready) begin
          n.reply = usb_ep_pkg::RPL_DATA;
        end else begin
          n.reply = usb_ep_pkg::RPL_NAK;
        end
      end else if (!r.ep_en[LNK_TOKEN_EP]) begin
        n.reply = usb_ep_pkg::RPL_NONE;
      end else if (r.send_stall[t] && !r.hi[t][usb_ep_pkg::IH_ISO]) begin
        n.reply         = usb_ep_pkg::RPL_STALL;
        n.sent_stall[t] = 1'b1;
        n.pkts[t]       = 2'h0;
        n.in_ready[t]   = 1'b0;
        n.fw_flush      = 1'b1;
      end else if (r.pkts[t] != 2'h0 && !r.iso_hold[t]) begin
        n.reply = usb_ep_pkg::RPL_DATA;
      end else if (r.hi[t][usb_ep_pkg::IH_ISO]) begin
        n.reply       = usb_ep_pkg::RPL_ZLP;
        n.underrun[t] = 1'b1;
      end else begin
        n.reply       = usb_ep_pkg::RPL_NAK;
        n.underrun[t] = 1'b1;
      end
    end
    if (LNK_IN_SENT && LNK_TOKEN_EP != 2'h0 && r.pkts[t] != 2'h0) begin
      n.pkts[t]   = 2'(r.pkts[t] - 2'h1);
      n.in_ready[t] = 1'b0;
      n.irq_in[LNK_TOKEN_EP] = r.in_ie[LNK_TOKEN_EP];
    end

    // endpoint setup outputs
    n.hs_en = {n.ep_en[3:1], 1'b1};
    for (int i = 0; i < 3; i++) begin
      n.split[i]     = n.hi[i][usb_ep_pkg::IH_SPLIT];
      n.force_tgl[i] = n.hi[i][usb_ep_pkg::IH_FORCE_TOGGLE];
      n.dir_in[i]    = !n.hi[i][usb_ep_pkg::IH_SPLIT] &&
                       n.hi[i][usb_ep_pkg::IH_DIRECTION_SELECT];
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r        <= '0;
      r.in_ie  <= usb_ep_pkg::RST_IN_IE;
      r.out_ie <= usb_ep_pkg::RST_OUT_IE;
      r.cm_ie  <= usb_ep_pkg::RST_CM_IE;
      r.ep_en  <= usb_ep_pkg::RST_EN;
      r.hs_en  <= usb_ep_pkg::RST_EN;
      r.reply  <= usb_ep_pkg::RPL_NONE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // transmit fifo
  // ----------------------------------------------------------------
  assign fw_s.data  = r.fw_data;
  assign fw_s.valid = r.fw_valid;
  assign fw_s.flush = r.fw_flush;
  assign tx_s.ready = TX_READY;

  byte_fifo #(
    .W     (usb_ep_pkg::FIFO_W),
    .DEPTH (usb_ep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk   (MCLK),
    .rst_n (ARST_N),
    .in_s  (fw_s),
    .out_s (tx_s)
  );

  assign REG_RDATA    = r.rdata;
  assign FIFO_READY   = fw_s.ready;
  assign TX_DATA      = tx_s.data;
  assign TX_VALID     = tx_s.valid;
  assign IN_REPLY     = r.reply;
  assign IN_REPLY_EP  = r.reply_ep;
  assign HS_EN        = r.hs_en;
  assign EP_DIR_IN    = r.dir_in;
  assign EP_SPLIT     = r.split;
  assign FORCE_TOGGLE = r.force_tgl;
  assign DT_CLEAR     = r.dt_clear;
  assign IRQ_IN       = r.irq_in;
  assign IRQ_OUT      = r.irq_out;
  assign IRQ_CM       = r.irq_cm;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  serviced_setup_end_clears_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    dwr && r.idx == usb_ep_pkg::IDX_CSRL && e0_sel && REG_WDATA[7] &&
    !LNK_SETUP_END |=> !r.e0_setup_end)
    else $error("setup end not cleared");

  out_packet_ready_only_clear_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $fell(r.e0_out_ready) |-> $past(dwr && e0_sel && REG_WDATA[6] &&
                                    r.idx == usb_ep_pkg::IDX_CSRL))
    else $error("out ready cleared without firmware");

  setup_end_set_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    LNK_SETUP_END && !r.e0_data_end |=> r.e0_setup_end [*1])
    else $error("setup end not set");

  data_end_auto_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    LNK_STATUS_DONE && !dwr |=> !r.e0_data_end)
    else $error("data end not cleared");

  ep0_overwrite_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    r.e0_in_ready && LNK_EP0_OVERWRITE |=>
    !r.e0_in_ready && r.irq_in[0] == $past(r.in_ie[0]))
    else $error("ep0 in ready not released");

  ep0_count_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    LNK_EP0_RX |=> r.e0_count == $past(LNK_EP0_COUNT) && r.e0_out_ready)
    else $error("ep0 count wrong");

  ep_off_quiet_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    LNK_IN_TOKEN && LNK_TOKEN_EP != 2'h0 && !r.ep_en[LNK_TOKEN_EP] |=>
    r.reply == usb_ep_pkg::RPL_NONE)
    else $error("disabled endpoint replied");

  stall_effects_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    r.reply == usb_ep_pkg::RPL_STALL && r.reply_ep != 2'h0 |->
    r.sent_stall[ep_slot(r.reply_ep)] && r.pkts[ep_slot(r.reply_ep)] == 2'h0)
    else $error("stall side effects missing");

  nak_underrun_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    r.reply == usb_ep_pkg::RPL_NAK && r.reply_ep != 2'h0 |->
    r.underrun[ep_slot(r.reply_ep)])
    else $error("nak without underrun");

  zlp_underrun_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    r.reply == usb_ep_pkg::RPL_ZLP |-> r.underrun[ep_slot(r.reply_ep)] &&
    r.hi[ep_slot(r.reply_ep)][usb_ep_pkg::IH_ISO])
    else $error("zero length without underrun");

  sent_irq_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    LNK_IN_SENT && LNK_TOKEN_EP != 2'h0 && r.pkts[t] != 2'h0 |=>
    r.irq_in[$past(LNK_TOKEN_EP)] == $past(r.in_ie[LNK_TOKEN_EP]))
    else $error("in irq missing");

endmodule

// File: verification/usb_host_model.sv
`timescale 1ns/10ps
module usb_host_model (
  // clock and transmit stream
  input  wire logic        clk,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  // link events
  output logic      [12:0] ev,
  output logic      [1:0]  ep,
  output logic      [6:0]  cnt
);
  // ----------------------------------------------------------------
  // host side
  // ----------------------------------------------------------------
  logic stall;
  int   got;
  logic [7:0] last;
  initial begin
    ev = '0;
    ep = 2'h0;
    cnt = 7'h00;
    stall = 1'b1;
    got = 0;
    last = 8'h00;
  end
  // host may hold off the stream, so the fifo really fills
  assign tx_ready = ~stall;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got <= got + 1;
      last <= tx_data;
    end
  end
  // one-cycle event pulse; endpoint number stays put afterwards
  task automatic evt(input int k, input logic [1:0] e);
    @(negedge clk);
    ev[k] = 1'b1;
    ep = e;
    @(negedge clk);
    ev = '0;
  endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic MCLK, ARST_N, REG_SEL, REG_WR, REG_RD, FIFO_READY, TX_VALID;
  logic TX_READY;
  logic [7:0]  REG_WDATA, REG_RDATA, q;
  logic [4:0]  IN_REPLY;
  logic [3:0]  HS_EN, IRQ_IN, IRQ_CM;
  logic [2:0]  EP_DIR_IN, IRQ_OUT;
  logic [12:0] ev;
  logic [1:0]  ep;
  logic [6:0]  cnt;
  logic [7:0]  TX_DATA;
  logic [1:0]  IN_REPLY_EP;
  logic [2:0]  EP_SPLIT, FORCE_TOGGLE, DT_CLEAR;
  int          miscompares, cmp_count, cyc, n;
  usb_host_model p (.clk(MCLK), .tx_valid(TX_VALID), .tx_data(TX_DATA),
    .tx_ready(TX_READY),
    .ev(ev), .ep(ep), .cnt(cnt));
  usb_ep_ctrl dut (.MCLK(MCLK), .ARST_N(ARST_N), .REG_SEL(REG_SEL),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .FIFO_READY(FIFO_READY), .LNK_IN_TOKEN(ev[0]),
    .LNK_IN_SENT(ev[1]), .LNK_TOKEN_EP(ep), .LNK_EP0_RX(ev[2]),
    .LNK_EP0_COUNT(cnt), .LNK_EP0_OVERWRITE(ev[3]),
    .LNK_SETUP_END(ev[4]), .LNK_STATUS_DONE(ev[5]), .LNK_SOF(ev[6]),
    .LNK_BUS_RESET(ev[7]), .LNK_RESUME(ev[8]), .LNK_SUSPEND(ev[9]),
    .LNK_OUT_RX(ev[12:10]), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .IN_REPLY(IN_REPLY), .IN_REPLY_EP(IN_REPLY_EP),
    .HS_EN(HS_EN), .EP_DIR_IN(EP_DIR_IN), .EP_SPLIT(EP_SPLIT),
    .FORCE_TOGGLE(FORCE_TOGGLE), .DT_CLEAR(DT_CLEAR), .IRQ_IN(IRQ_IN),
    .IRQ_OUT(IRQ_OUT), .IRQ_CM(IRQ_CM));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic acc(input logic s, w, input logic [7:0] d);
    @(negedge MCLK);
    REG_SEL = s;
    REG_WR = w;
    REG_RD = ~w;
    REG_WDATA = d;
    @(negedge MCLK);
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(1'b0, 1'b1, a);
    acc(1'b1, 1'b1, d);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // read data lands one edge after the read strobe
  task automatic cr(input logic [7:0] a, e, input string nm);
    acc(1'b0, 1'b1, a);
    acc(1'b1, 1'b0, 8'h00);
    @(negedge MCLK);
    chk(nm, e, REG_RDATA);
  endtask
  task automatic tok(input logic [7:0] e);
    p.evt(0, 2'h1);
    chk("reply", e, {3'h0, IN_REPLY});
    chk("reply_ep", 8'h01, {6'h0, IN_REPLY_EP});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, reset, hang guard
  // ----------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    {REG_SEL, REG_WR, REG_RD, REG_WDATA} = '0;
    ARST_N = 1'b0;
    repeat (4) @(negedge MCLK);
    ARST_N = 1'b1;
    cr(8'h07, 8'h0F, "in_ie");
    cr(8'h09, 8'h0E, "out_ie");
    cr(8'h0B, 8'h06, "cm_ie");
    cr(8'h1E, 8'h0F, "ep_en");
    cr(8'h3F, 8'h00, "unmapped");
    wr(8'h07, 8'hFF);
    cr(8'h07, 8'h0F, "in_ie_wr");
    wr(8'h0B, 8'hF9);
    cr(8'h0B, 8'h09, "cm_ie_wr");
    $display("test registers done");
    p.cnt = 7'h45;
    p.evt(2, 2'h0);
    cr(8'h11, 8'h01, "e0_opr");
    cr(8'h16, 8'h45, "e0_cnt");
    wr(8'h11, 8'h40);
    cr(8'h11, 8'h00, "e0_sopr");
    p.evt(4, 2'h0);
    cr(8'h11, 8'h10, "setup_end");
    wr(8'h11, 8'h80);
    cr(8'h11, 8'h00, "serviced_setup_end");
    wr(8'h11, 8'h0A);
    p.evt(3, 2'h0);
    chk("irq_e0", 8'h01, {4'h0, IRQ_IN});
    cr(8'h11, 8'h08, "e0_inrdy");
    p.evt(5, 2'h0);
    cr(8'h11, 8'h00, "dend");
    $display("test endpoint0 done");
    wr(8'h0E, 8'h01);
    n = 0;
    while (FIFO_READY === 1'b1 && n < 20) begin
      wr(8'h20, 8'(n));
      @(negedge MCLK);
      n++;
    end
    chk("fifo_full", 8'h00, {7'h0, FIFO_READY});
    wr(8'h11, 8'h01);
    cr(8'h11, 8'h03, "loaded");
    tok(8'h04);
    p.stall = 1'b0;
    repeat (n + 6) @(negedge MCLK);
    p.stall = 1'b1;
    chk("drained", 8'(n), 8'(p.got));
    chk("last_byte", 8'(n - 1), p.last);
    p.evt(1, 2'h1);
    chk("irq_e1", 8'h02, {4'h0, IRQ_IN});
    cr(8'h11, 8'h00, "sent");
    tok(8'h02);
    cr(8'h11, 8'h04, "in_underrun");
    wr(8'h11, 8'h10);
    tok(8'h08);
    cr(8'h11, 8'h30, "sent_stall");
    wr(8'h11, 8'h00);
    wr(8'h11, 8'h40);
    chk("dt_clear", 8'h01, {5'h0, DT_CLEAR});
    $display("test bulk done");
    wr(8'h12, 8'h80);
    cr(8'h12, 8'h80, "dbl");
    wr(8'h20, 8'h5A);
    wr(8'h11, 8'h01);
    cr(8'h11, 8'h02, "dbl_rdy");
    wr(8'h11, 8'h08);
    wr(8'h12, 8'h40);
    cr(8'h12, 8'h40, "iso");
    tok(8'h10);
    cr(8'h11, 8'h04, "iso_undr");
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h41);
    wr(8'h20, 8'h33);
    wr(8'h11, 8'h01);
    cr(8'h11, 8'h02, "isochronous_update");
    p.evt(6, 2'h0);
    chk("irq_sof", 8'h08, {4'h0, IRQ_CM});
    cr(8'h11, 8'h03, "isochronous_update_sof");
    wr(8'h11, 8'h08);
    $display("test iso done");
    wr(8'h12, 8'h24);
    repeat (2) @(negedge MCLK);
    chk("dir_split", 8'h00, {5'h0, EP_DIR_IN});
    chk("split", 8'h01, {5'h0, EP_SPLIT});
    wr(8'h12, 8'h20);
    repeat (2) @(negedge MCLK);
    chk("dir", 8'h01, {5'h0, EP_DIR_IN});
    wr(8'h12, 8'h28);
    repeat (2) @(negedge MCLK);
    chk("force_toggle", 8'h01, {5'h0, FORCE_TOGGLE});
    wr(8'h1E, 8'h0D);
    chk("hs_en", 8'h0D, {4'h0, HS_EN});
    tok(8'h01);
    wr(8'h09, 8'h04);
    p.evt(11, 2'h0);
    chk("irq_out", 8'h02, {5'h0, IRQ_OUT});
    p.evt(7, 2'h0);
    chk("irq_rst", 8'h00, {4'h0, IRQ_CM});
    $display("test enables done");
    give_verdict();
  end
endmodule
